// File: rtl/bec_sync.sv
`timescale 1ns/1ps
package bec_pkg;
    localparam logic [2:0]  CODE_NORMAL   = 3'h0;
    localparam logic [2:0]  CODE_HALT     = 3'h1;
    localparam logic [2:0]  CODE_BERR     = 3'h2;
    localparam logic [2:0]  CODE_RETRY    = 3'h3;
    localparam logic [2:0]  CODE_RELQ     = 3'h4;
    localparam logic [2:0]  CODE_UNDEF_A  = 3'h5;
    localparam logic [2:0]  CODE_UNDEF_B  = 3'h6;
    localparam logic [2:0]  CODE_RESET    = 3'h7;
    localparam int          DEPTH_ACK     = 3;
    localparam int          DEPTH_CODE    = 4;
    localparam logic [4:0]  RESUME_CLKS   = 5'h03;
    localparam logic [4:0]  RECOV_SINGLE  = 5'h19;
    localparam logic [4:0]  RECOV_DUAL_WR = 5'h1d;
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [3:0]  OFS_ERR       = 4'h8;
    localparam logic [0:0]  CTRL_RESET    = 1'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_OWN  = 7'h02,
        ST_CYC  = 7'h04,
        ST_SW   = 7'h08,
        ST_HOLD = 7'h10,
        ST_DLY  = 7'h20,
        ST_RST  = 7'h40
    } bec_state_e;
    typedef struct packed {
        logic cycle_end;
        logic abort;
        logic internal_reset;
    } bec_evt_s;
endpackage

// active-low pins are inverted at capture; the last two stages must agree
module bec_sync #(
    parameter int W     = 3,
    parameter int DEPTH = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin_n,
    output logic      [W-1:0] stable,
    output logic      [W-1:0] peek
);
    logic [W-1:0] stage [DEPTH];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage[0] <= '0;
        end else begin
            stage[0] <= ~pin_n;
        end
    end

    for (genvar i = 1; i < DEPTH; i++) begin : g_chain
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage[i] <= '0;
            end else begin
                stage[i] <= stage[i-1];
            end
        end
    end

    // a mismatch keeps the old value and is compared again next clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable <= '0;
        end else if (stage[DEPTH-1] == stage[DEPTH-2]) begin
            stable <= stage[DEPTH-1];
        end
    end

    assign peek = stage[DEPTH-1];
endmodule

// File: rtl/bec_ctrl.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// How it works
// RQ1: pins captured each edge, then synchronised next edge
// RQ2: extra stage; accept only two matching samples
// RQ3: encoder holds each code two clocks minimum
// RQ4: active-low pins read as binary, bit0 lowest
// RQ5: abnormal end is two clocks after acknowledge end
// RQ6: abnormal code beats simultaneous acknowledge
// RQ7: nonzero code idles block until code clears
// RQ8: code zero: cycles end on acknowledge only
// RQ9: halt ends on acknowledge, releases bus, resumes
// RQ10: halt must precede next cycle by sync+debounce
// RQ11: halt with acknowledge ends two clocks later
// RQ12: after halt wait three clocks before request
// RQ13: bus error aborts cycle and logs channel error
// RQ14: error recovery 25 or 29 clocks
// RQ15: bus error: no complete strobe, counters held
// RQ16: retry keeps grant, waits three, reruns cycle
// RQ17: retry: no complete strobe, counters held
// RQ18: relinquish releases bus, waits three, reruns
// RQ19: retried operand finishes before other channels
// RQ20: relinquish: no complete strobe, counters held
// RQ21: codes five, six stretch cycle until zero
// RQ22: code seven runs internal reset, then idles
// RQ23: complete strobe only on successful cycle end
module bec_ctrl (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [2:0]         exception_code_in_n,
    input  wire logic               transfer_ack_in_n,
    input  wire logic               service_pending_in,
    input  wire logic               grant_in,
    input  wire logic               cycle_start_in,
    input  wire logic               dual_write_in,
    input  wire logic [1:0]         channel_in,
    input  wire logic               operand_done_in,
    output logic                    bus_request_out,
    output logic                    grant_ack_out,
    output logic                    transfer_complete_out,
    output logic                    service_allow_out,
    output logic                    rerun_out,
    output logic                    chan_lock_out,
    output logic                    idle_out,
    output bec_pkg::bec_evt_s       evt_out
);
    logic [2:0]         code;
    logic [2:0]         code_peek;
    logic               ack_stable;
    bec_pkg::bec_state_e state;
    bec_pkg::bec_state_e next_state;
    logic [2:0]         hold_code;
    logic [2:0]         next_hold;
    logic [4:0]         cnt;
    logic [4:0]         next_cnt;
    logic               next_br;
    logic               next_gack;
    logic               next_cmpl;
    logic               next_rerun;
    logic               next_lock;
    bec_pkg::bec_evt_s  next_evt;
    logic [3:0]         err_set;
    logic               dual_q;
    logic [1:0]         chan_q;
    logic               enable;
    logic [3:0]         err_flags;
    logic [31:0]        wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;

    function automatic logic is_abn(input logic [2:0] c);
        is_abn = (c == bec_pkg::CODE_BERR) || (c == bec_pkg::CODE_RETRY) || (c == bec_pkg::CODE_RELQ);
    endfunction

    function automatic logic is_undef(input logic [2:0] c);
        is_undef = (c == bec_pkg::CODE_UNDEF_A) || (c == bec_pkg::CODE_UNDEF_B);
    endfunction

    // the code path has one stage more than the acknowledge path
    bec_sync #(.W(3), .DEPTH(bec_pkg::DEPTH_CODE)) u_code_sync ( // see RQ1 see RQ2 see RQ4
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_n   (exception_code_in_n),
        .stable  (code),
        .peek    (code_peek)
    );

    bec_sync #(.W(1), .DEPTH(bec_pkg::DEPTH_ACK)) u_ack_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_n   (transfer_ack_in_n),
        .stable  (ack_stable),
        .peek    ()
    );

    // acknowledge waits while a code sample of the same age is still pending
    wire ack_ok     = ack_stable && (code_peek == bec_pkg::CODE_NORMAL); // see RQ6
    wire code_zero  = (code == bec_pkg::CODE_NORMAL);
    wire code_reset = (code == bec_pkg::CODE_RESET);
    wire [2:0] idle_hold = (is_undef(code) || code == bec_pkg::CODE_RETRY) ? code : bec_pkg::CODE_HALT;
    wire [4:0] recov_len = dual_q ? bec_pkg::RECOV_DUAL_WR : bec_pkg::RECOV_SINGLE; // see RQ14

    always_comb begin
        next_state = state;
        next_hold  = hold_code;
        next_cnt   = cnt;
        next_br    = bus_request_out;
        next_gack  = grant_ack_out;
        next_cmpl  = 1'b0;
        next_evt   = '0;
        next_rerun = rerun_out;
        next_lock  = chan_lock_out && !operand_done_in;
        err_set    = '0;
        case (state)
            bec_pkg::ST_IDLE: begin
                if (code_reset) begin
                    next_state = bec_pkg::ST_RST;
                end else if (!code_zero) begin
                    next_br    = 1'b0;
                    next_hold  = idle_hold;
                    next_state = bec_pkg::ST_HOLD; // see RQ7
                end else if (bus_request_out && grant_in) begin
                    next_br    = 1'b0;
                    next_gack  = 1'b1;
                    next_state = bec_pkg::ST_OWN;
                end else begin
                    next_br = enable && (service_pending_in || chan_lock_out);
                end
            end
            bec_pkg::ST_OWN: begin
                if (code_reset) begin
                    next_state = bec_pkg::ST_RST;
                end else if (!code_zero) begin
                    next_hold  = idle_hold;
                    next_gack  = (code == bec_pkg::CODE_RETRY) || is_undef(code); // see RQ21
                    next_state = bec_pkg::ST_HOLD; // see RQ7 see RQ10
                end else if (cycle_start_in) begin
                    next_rerun = 1'b0;
                    next_state = bec_pkg::ST_CYC;
                end else if (!service_pending_in && !chan_lock_out && !rerun_out) begin
                    next_gack  = 1'b0;
                    next_state = bec_pkg::ST_IDLE;
                end
            end
            bec_pkg::ST_CYC: begin
                if (code_reset) begin
                    next_state = bec_pkg::ST_RST;
                end else if (is_abn(code)) begin
                    next_hold  = code;
                    next_state = bec_pkg::ST_SW; // see RQ5 see RQ6
                end else if (code == bec_pkg::CODE_HALT) begin
                    if (ack_stable) begin
                        next_hold  = code;
                        next_state = bec_pkg::ST_SW; // see RQ9 see RQ11
                    end
                end else if (code_zero && ack_ok) begin
                    next_cmpl          = 1'b1;
                    next_evt.cycle_end = 1'b1;
                    next_state         = bec_pkg::ST_OWN; // see RQ8 see RQ23
                end
            end
            bec_pkg::ST_SW: begin
                next_evt.cycle_end = 1'b1;
                next_cmpl          = (hold_code == bec_pkg::CODE_HALT); // see RQ15 see RQ17 see RQ20
                if (hold_code == bec_pkg::CODE_BERR) begin
                    next_evt.abort  = 1'b1;
                    err_set[chan_q] = 1'b1; // see RQ13
                end
                if (hold_code == bec_pkg::CODE_RETRY || hold_code == bec_pkg::CODE_RELQ) begin
                    next_rerun = 1'b1;
                end
                if (hold_code == bec_pkg::CODE_RELQ) begin
                    next_lock = 1'b1; // see RQ19
                end
                if (hold_code == bec_pkg::CODE_HALT || hold_code == bec_pkg::CODE_RELQ) begin
                    next_gack = 1'b0; // see RQ9 see RQ18
                end
                // a reset code must not wait a clock in hold
                next_state = code_reset ? bec_pkg::ST_RST : bec_pkg::ST_HOLD; // see RQ22
            end
            bec_pkg::ST_HOLD: begin
                if (code_reset && hold_code != bec_pkg::CODE_RESET) begin
                    next_state = bec_pkg::ST_RST;
                end else if (code_zero) begin
                    if (hold_code == bec_pkg::CODE_BERR) begin
                        next_cnt   = recov_len;
                        next_state = bec_pkg::ST_DLY;
                    end else if (is_abn(hold_code) || hold_code == bec_pkg::CODE_HALT) begin
                        next_cnt   = bec_pkg::RESUME_CLKS; // see RQ12 see RQ16 see RQ18
                        next_state = bec_pkg::ST_DLY;
                    end else begin
                        next_state = grant_ack_out ? bec_pkg::ST_OWN : bec_pkg::ST_IDLE; // see RQ21
                    end
                end
            end
            bec_pkg::ST_DLY: begin
                if (code_reset) begin
                    next_state = bec_pkg::ST_RST;
                end else if (!code_zero) begin
                    next_state = bec_pkg::ST_HOLD;
                end else if (cnt == 5'h01) begin
                    if (hold_code == bec_pkg::CODE_HALT || hold_code == bec_pkg::CODE_RELQ) begin
                        next_gack  = 1'b0;
                        next_br    = enable && (service_pending_in || chan_lock_out);
                        next_state = bec_pkg::ST_IDLE;
                    end else begin
                        next_state = bec_pkg::ST_OWN;
                    end
                end else begin
                    next_cnt = cnt - 5'h01;
                end
            end
            bec_pkg::ST_RST: begin
                next_evt.internal_reset = 1'b1; // see RQ22
                next_br    = 1'b0;
                next_gack  = 1'b0;
                next_rerun = 1'b0;
                next_lock  = 1'b0;
                next_hold  = bec_pkg::CODE_RESET;
                next_state = bec_pkg::ST_HOLD;
            end
            default: begin
                next_state = bec_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                 <= bec_pkg::ST_IDLE;
            hold_code             <= bec_pkg::CODE_NORMAL;
            cnt                   <= '0;
            bus_request_out       <= 1'b0;
            grant_ack_out         <= 1'b0;
            transfer_complete_out <= 1'b0;
            evt_out               <= '0;
            rerun_out             <= 1'b0;
            chan_lock_out         <= 1'b0;
        end else begin
            state                 <= next_state;
            hold_code             <= next_hold;
            cnt                   <= next_cnt;
            bus_request_out       <= next_br;
            grant_ack_out         <= next_gack;
            transfer_complete_out <= next_cmpl;
            evt_out               <= next_evt;
            rerun_out             <= next_rerun;
            chan_lock_out         <= next_lock;
        end
    end

    // a code of zero is already debounced, so service may start at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            service_allow_out <= 1'b0;
            idle_out          <= 1'b1;
            dual_q            <= 1'b0;
            chan_q            <= '0;
        end else begin
            service_allow_out <= (next_state == bec_pkg::ST_OWN) && code_zero;
            idle_out          <= (next_state == bec_pkg::ST_IDLE) || (next_state == bec_pkg::ST_HOLD && !next_gack);
            dual_q            <= cycle_start_in ? dual_write_in : dual_q;
            chan_q            <= cycle_start_in ? channel_in : chan_q;
        end
    end

    wire wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl  = wr_addr[3:0] == bec_pkg::OFS_CTRL;
    wire wr_err   = wr_addr[3:0] == bec_pkg::OFS_ERR;
    wire wr_map   = (wr_addr[31:4] == '0) && (wr_ctrl || wr_err || wr_addr[3:0] == bec_pkg::OFS_STATUS);
    wire [3:0] err_clr = (wr_fire && wr_map && wr_err && wr_strb[0]) ? wr_data[3:0] : 4'h0;
    wire [3:0] ra      = s_axi_araddr[3:0];
    wire rd_map   = (s_axi_araddr[31:4] == '0) && (ra == bec_pkg::OFS_CTRL || ra == bec_pkg::OFS_STATUS
                    || ra == bec_pkg::OFS_ERR);
    wire [31:0] status_word = {17'h0, state, 1'b0, rerun_out, bus_request_out, grant_ack_out, idle_out, code};
    wire [31:0] rd_word = (ra == bec_pkg::OFS_CTRL) ? {31'h0, enable} :
                          (ra == bec_pkg::OFS_STATUS) ? status_word :
                          (ra == bec_pkg::OFS_ERR) ? {28'h0, err_flags} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= bec_pkg::RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? bec_pkg::RESP_OKAY : bec_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= bec_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_map ? bec_pkg::RESP_OKAY : bec_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // a new error wins over a clear written in the same clock
    always_ff @(posedge aclk) begin
        if (!aresetn || evt_out.internal_reset) begin
            enable    <= bec_pkg::CTRL_RESET;
            err_flags <= '0;
        end else begin
            err_flags <= (err_flags & ~err_clr) | err_set; // see RQ13
            if (wr_fire && wr_ctrl && wr_addr[31:4] == '0 && wr_strb[0]) begin
                enable <= wr_data[0];
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_abn_seen;
        state == bec_pkg::ST_CYC && is_abn(code) && !code_reset;
    endsequence

    sequence s_abn_end;
        state == bec_pkg::ST_SW ##1 evt_out.cycle_end && !transfer_complete_out;
    endsequence

    AST_ABN_TERM: assert property (s_abn_seen |=> s_abn_end) // see RQ5
        else $error("abnormal code did not end the cycle after one switching clock");
    AST_NO_CMPL_ABORT: assert property (evt_out.abort |-> !transfer_complete_out) // see RQ15
        else $error("complete strobe raised on a bus error abort");
    AST_NORMAL_END: assert property (state == bec_pkg::ST_CYC && code_zero && ack_ok // see RQ8
        |=> transfer_complete_out && evt_out.cycle_end && state == bec_pkg::ST_OWN)
        else $error("acknowledge with code zero did not complete the cycle");
    AST_HALT_ACK: assert property (state == bec_pkg::ST_CYC && code == bec_pkg::CODE_HALT && ack_stable // see RQ11
        |=> state == bec_pkg::ST_SW ##1 transfer_complete_out && !grant_ack_out)
        else $error("halt with acknowledge did not end and release the bus");
    AST_HALT_BR: assert property (state == bec_pkg::ST_HOLD && hold_code == bec_pkg::CODE_HALT && code_zero // see RQ12
        && enable && service_pending_in |=> !bus_request_out [*3] ##1 bus_request_out)
        else $error("bus request after halt not raised on the fourth clock");
    AST_RECOV_LEN: assert property (state == bec_pkg::ST_HOLD && hold_code == bec_pkg::CODE_BERR && code_zero // see RQ14
        |=> state == bec_pkg::ST_DLY && cnt == (dual_q ? 5'h1d : 5'h19))
        else $error("recovery length wrong");
    AST_RETRY_GRANT: assert property (state == bec_pkg::ST_HOLD && hold_code == bec_pkg::CODE_RETRY // see RQ16
        && $past(state) == bec_pkg::ST_SW |-> grant_ack_out && rerun_out)
        else $error("retry lost the grant or the rerun request");
    AST_RELQ_FREE: assert property (state == bec_pkg::ST_HOLD && hold_code == bec_pkg::CODE_RELQ // see RQ18
        |-> !grant_ack_out && chan_lock_out && rerun_out)
        else $error("relinquish kept the bus or dropped the rerun");
    AST_STRETCH: assert property (state == bec_pkg::ST_CYC && is_undef(code) // see RQ21
        |=> state == bec_pkg::ST_CYC && !evt_out.cycle_end)
        else $error("undefined code did not stretch the cycle");
    AST_RESET_SEQ: assert property (code_reset && state != bec_pkg::ST_RST && state != bec_pkg::ST_HOLD // see RQ22
        |=> state == bec_pkg::ST_RST ##1 evt_out.internal_reset && idle_out)
        else $error("reset code did not start the internal reset");
    AST_HOLD_IDLE: assert property (state == bec_pkg::ST_HOLD && !code_zero // see RQ7
        |=> state == bec_pkg::ST_HOLD || state == bec_pkg::ST_RST)
        else $error("cycle started while a code was present");
endmodule

// File: tb/bec_partner.sv
`timescale 1ns/1ps
module bec_partner (
    input  wire logic       aclk,
    input  wire logic [2:0] code,
    input  wire logic       ack,
    input  wire logic       bus_request_out,
    output logic [2:0]      exception_code_in_n,
    output logic            transfer_ack_in_n,
    output logic            grant_in
);
    initial begin
        exception_code_in_n = 3'h7;
        transfer_ack_in_n = 1'b1;
        grant_in = 1'b0;
    end
    // the bench holds every code for many clocks, so no transitional code reaches the pins
    always @(posedge aclk) begin
        exception_code_in_n <= ~code;
        transfer_ack_in_n <= ~ack;
        grant_in <= bus_request_out;
    end
endmodule

// File: tb/bec_ctrl_tb.sv
`timescale 1ns/1ps
module bec_ctrl_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, cmp, ab;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf, obs;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, channel_in = 2'h1;
    logic [2:0]  code = 3'h0, exception_code_in_n;
    logic        ack = 1'b0, transfer_ack_in_n, grant_in, service_pending_in = 1'b0, cycle_start_in = 1'b0;
    logic        dual_write_in = 1'b0, operand_done_in = 1'b0, bus_request_out, grant_ack_out;
    logic        transfer_complete_out, service_allow_out, rerun_out, chan_lock_out, idle_out;
    bec_pkg::bec_evt_s evt_out;
    int          fails = 0, n_checks = 0, base, n, k;
    assign obs = {service_allow_out, grant_ack_out, idle_out, evt_out.internal_reset};
    always #5 aclk = ~aclk;
    bec_ctrl i_dut (.*);
    bec_partner i_far (.*);
    task end_of_test;
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tmo(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %0t wait timed out", $time);
            end_of_test();
        end
    endtask
    // sampled on the falling edge so registered outputs have settled
    task wait_bit(input int b, input logic v, output int c);
        for (c = 0; c < 400; c++) begin
            @(negedge aclk);
            if (obs[b] === v) break;
        end
        tmo(obs[b] === v);
        @(posedge aclk);
    endtask
    task axw(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        tmo(s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        tmo(s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    // code and acknowledge reach the pins on the same edge
    task start_cyc(input logic [2:0] c);
        service_pending_in <= 1'b1;
        wait_bit(3, 1'b1, n);
        cycle_start_in <= 1'b1;
        @(posedge aclk);
        cycle_start_in <= 1'b0;
        ack <= 1'b1;
        code <= c;
        cmp = 1'b0;
        ab = 1'b0;
    endtask
    // acknowledge is a level: it must have settled low before the next cycle starts
    task end_cyc(output int e);
        for (e = 0; e < 60; e++) begin
            @(negedge aclk);
            cmp |= transfer_complete_out;
            ab |= evt_out.abort;
            if (evt_out.cycle_end === 1'b1) break;
        end
        tmo(evt_out.cycle_end);
        @(posedge aclk);
        ack <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    task run_cyc(input logic [2:0] c, output int e);
        start_cyc(c);
        end_cyc(e);
    endtask
    task t_exc(input logic [2:0] c);
        run_cyc(c, n);
        chk(n, base + 2);
        chk(cmp, c == 3'h1);
        chk(ab, c == 3'h2);
        if (c == 3'h2 || c == 3'h3)
            chk(grant_ack_out, 1'b1);
        else
            wait_bit(2, 1'b0, n);
        chk(idle_out, c == 3'h1 || c == 3'h4);
        code <= 3'h0;
        wait_bit(3, 1'b1, n);
        chk(rerun_out, c == 3'h3 || c == 3'h4);
        chk(chan_lock_out, c == 3'h4);
        // zero is acted on seven clocks after it is driven; halt and relinquish then re-arbitrate
        chk(n, (c == 3'h2) ? (dual_write_in ? 32'd36 : 32'd32) : (c == 3'h3) ? 32'd10 : 32'd12);
        if (c == 3'h2) begin
            axr(32'h8);
            chk(rd, 32'h2);
            axw(32'h8, 32'h2);
            axr(32'h8);
            chk(rd, 32'h0);
        end
    endtask
    task t_rst;
        axw(32'h0, 32'h0);
        code <= 3'h7;
        wait_bit(0, 1'b1, n);
        chk(idle_out, 1'b1);
        code <= 3'h0;
        axr(32'h0);
        chk(rd, 32'h1);
    endtask
    // an undefined code stretches the cycle even with the acknowledge held high
    task t_undef;
        start_cyc(3'h5);
        repeat (20) begin
            @(negedge aclk);
            ab |= evt_out.cycle_end;
        end
        chk(ab, 1'b0);
        @(posedge aclk);
        code <= 3'h0;
        end_cyc(n);
        chk(n, 32'd7);
        chk(cmp, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(32'h4);
        chk(rd, 32'h108);
        axw(32'hc, 32'h0);
        chk(rsp, 2'h2);
        run_cyc(3'h0, base);
        chk(cmp, 1'b1);
        chk(base, 32'd6);
        dual_write_in <= 1'b1;
        t_exc(3'h2);
        dual_write_in <= 1'b0;
        for (int c = 1; c < 5; c++)
            t_exc(c[2:0]);
        t_undef();
        t_rst();
        end_of_test();
    end
endmodule
